// [hdl/rtssi_consts.vh]
// Constants for the remote start/stop interlock block
`ifndef RTSSI_CONSTS_VH
`define RTSSI_CONSTS_VH

// Register byte offsets
`define RTSSI_CTRL_OFS    12'h000
`define RTSSI_STATE_OFS   12'h004
`define RTSSI_IRQST_OFS   12'h008
`define RTSSI_IRQMSK_OFS  12'h00C

// Control register fields
`define RTSSI_CTRL_TIMER  0
`define RTSSI_CTRL_RESET  32'h00000001

// Interrupt status fields
`define RTSSI_EV_PASS     0
`define RTSSI_EV_FAIL     1
`define RTSSI_EV_PROT     2
`define RTSSI_EV_REMOTE   3
`define RTSSI_EV_W        4

// Test sequencer states
`define RTSSI_ST_READY    3'h0
`define RTSSI_ST_TEST     3'h1
`define RTSSI_ST_PASS     3'h2
`define RTSSI_ST_FAIL     3'h3
`define RTSSI_ST_PROT     3'h4

// Timing, clock rate in kHz and times in ms
`define RTSSI_CLK_KHZ     10000
`define RTSSI_QUAL_MS     20
`define RTSSI_PASS_MS     200
`define RTSSI_QUAL_CYC    (`RTSSI_QUAL_MS * `RTSSI_CLK_KHZ)
`define RTSSI_PASS_CYC    (`RTSSI_PASS_MS * `RTSSI_CLK_KHZ)

`endif

// [hdl/rtssi_remote_interlock.v]
// Remote start/stop front end and test sequencer guard with APB registers
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "rtssi_consts.vh"

// The block sits between an external start/stop controller and the
// test sequencer. Remote pins are active low and idle high, so a cut
// cable can never start a test. Each pin must hold a new level for the
// qualification time before it counts, which rejects contact bounce at
// the cost of that much command latency. The interlock loop is not
// qualified: opening it must shut the output off on the next edge.

// Contract
// - Remote enable held low selects remote control; released high returns to panel.
// - Under remote control the panel start button is ignored.
// - Under remote control remote stop or panel stop both stop.
// - Remote, ready, remote start low begins a test like panel start.
// - Under remote control, remote stop low ends any running test and shuts output off.
// - Open remote inputs read high, meaning inactive.
// - Changeover contact to start side tests; back to stop side stops.
// - Open interlock loop forces protection, output off, starts refused.
// - While the loop stays open, stop commands do not leave protection.
// - Protection exits only after loop closes and a later stop arrives.
// - Fail is held, output off, until stop; then back to ready.
// - Timed test completion shows pass about 200 ms then ready.
module rtssi_remote_interlock #(
  parameter QUAL_CYC = `RTSSI_QUAL_CYC,
  parameter PASS_CYC = `RTSSI_PASS_CYC
) (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        remoteEnable_b,
  input  wire        remoteStart_b,
  input  wire        remoteStop_b,
  input  wire        panelStart,
  input  wire        panelStop,
  input  wire        interlockClosed,
  input  wire        timerDone,
  input  wire        leakFail,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg         outputOn,
  output reg  [2:0]  testState,
  output reg         remoteMode,
  output wire        irq
);

  // Reset release through two flops
  reg        rstSync1;
  reg        rstSync2;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  wire       rstN = rstSync2;

  // Remote inputs: synchroniser then stable-level qualifier, one per pin
  wire [2:0] rawIn = {remoteStop_b, remoteStart_b, remoteEnable_b};
  wire [2:0] qualIn;                      // Qualified active-low levels
  genvar     gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gQual
      reg        s1;
      reg        s2;
      reg        q;
      reg [31:0] cnt;
      // Idle high is the safe default, so an open pin reads inactive
      always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          q <= 1'b1;
          cnt <= 32'h00000000;
        end else begin
          s1 <= rawIn[gi];
          s2 <= s1;
          if (s2 == q) begin
            cnt <= 32'h00000000;
          end else if (cnt >= QUAL_CYC - 1) begin
            q <= s2;
            cnt <= 32'h00000000;
          end else begin
            cnt <= cnt + 32'h00000001;
          end
        end
      end
      assign qualIn[gi] = q;
    end
  endgenerate

  wire       remEn    = ~qualIn[0];
  wire       remStart = ~qualIn[1];
  wire       remStop  = ~qualIn[2];

  // Command decode depends on who has control
  reg        ctrlTimer;
  wire       startCmd = remoteMode ? remStart : panelStart;
  wire       stopCmd  = remoteMode ? (remStop | panelStop) : panelStop;

  // Protection is left only on a stop edge that comes after the loop closed
  reg        stopPrev;
  wire       stopEdge = stopCmd & ~stopPrev;

  reg [2:0]  next_state;
  reg [31:0] passCnt;
  always @* begin
    next_state = testState;
    case (testState)
      `RTSSI_ST_READY: begin
        if (startCmd && !stopCmd) begin
          next_state = `RTSSI_ST_TEST;
        end
      end
      `RTSSI_ST_TEST: begin
        if (stopCmd) begin
          next_state = `RTSSI_ST_READY;
        end else if (leakFail) begin
          next_state = `RTSSI_ST_FAIL;
        end else if (ctrlTimer && timerDone) begin
          next_state = `RTSSI_ST_PASS;
        end
      end
      `RTSSI_ST_PASS: begin
        if (passCnt >= PASS_CYC - 1) begin
          next_state = `RTSSI_ST_READY;
        end
      end
      `RTSSI_ST_FAIL: begin
        if (stopCmd) begin
          next_state = `RTSSI_ST_READY;
        end
      end
      `RTSSI_ST_PROT: begin
        if (interlockClosed && stopEdge) begin
          next_state = `RTSSI_ST_READY;
        end
      end
      default: begin
        next_state = `RTSSI_ST_PROT;
      end
    endcase
    // Open loop overrides everything, including a stop in the same cycle
    if (!interlockClosed) begin
      next_state = `RTSSI_ST_PROT;
    end
  end

  // Sequencer registers; output is on only while testing
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      testState <= `RTSSI_ST_READY;
      outputOn <= 1'b0;
      passCnt <= 32'h00000000;
      stopPrev <= 1'b0;
      remoteMode <= 1'b0;
    end else begin
      testState <= next_state;
      outputOn <= (next_state == `RTSSI_ST_TEST);
      stopPrev <= stopCmd;
      remoteMode <= remEn;
      if (testState == `RTSSI_ST_PASS) begin
        passCnt <= passCnt + 32'h00000001;
      end else begin
        passCnt <= 32'h00000000;
      end
    end
  end

  // Entry of a state is seen by comparing with last cycle's state
  reg  [2:0] prevState;
  reg        prevRemote;
  wire       enter = (testState != prevState);

  // One event bit per interrupt source, laid out as the status register
  wire [`RTSSI_EV_W-1:0] events;
  assign events[`RTSSI_EV_PASS]   = enter && (testState == `RTSSI_ST_PASS);
  assign events[`RTSSI_EV_FAIL]   = enter && (testState == `RTSSI_ST_FAIL);
  assign events[`RTSSI_EV_PROT]   = enter && (testState == `RTSSI_ST_PROT);
  assign events[`RTSSI_EV_REMOTE] = (remoteMode != prevRemote);

  // Change history for the event detectors
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      prevState <= `RTSSI_ST_READY;
      prevRemote <= 1'b0;
    end else begin
      prevState <= testState;
      prevRemote <= remoteMode;
    end
  end

  // Register map, one aligned word each:
  //   CTRL   bit 0 enables the timed pass judgement (reset 1)
  //   STATE  read only: [2:0] sequencer state, [3] output on,
  //          [4] remote control, [7:5] qualified stop, start, enable
  //   IRQST  sticky events: [0] pass, [1] fail, [2] protection,
  //          [3] control mode changed; a read clears what it returned
  //   IRQMSK same layout as IRQST, reset 0
  // Writes to read-only or unmapped words have no effect; unmapped
  // words also raise pslverr in the access phase.

  // APB slave: zero wait states, unmapped addresses answer with an error
  wire       acc     = psel & penable;
  wire       setup   = psel & ~penable;
  wire       wr      = acc & pwrite;
  wire       rd      = acc & ~pwrite;
  wire       rdSetup = setup & ~pwrite;
  wire       hitCtrl = (paddr == `RTSSI_CTRL_OFS);
  wire       hitSt   = (paddr == `RTSSI_STATE_OFS);
  wire       hitIrq  = (paddr == `RTSSI_IRQST_OFS);
  wire       hitMsk  = (paddr == `RTSSI_IRQMSK_OFS);
  wire       hitAny  = hitCtrl | hitSt | hitIrq | hitMsk;
  assign pready  = 1'b1;
  assign pslverr = acc & ~hitAny;

  // Status word as software sees it; qualified pin levels read 1 when active
  wire [31:0] stateWord = {24'h000000, remStop, remStart, remEn,
                           remoteMode, outputOn, testState};

  reg  [`RTSSI_EV_W-1:0] irqStatus;
  reg  [`RTSSI_EV_W-1:0] irqMask;
  reg  [31:0]            readMux;

  // Read mux; unmapped offsets read as zero
  always @* begin
    readMux = 32'h00000000;
    case (paddr)
      `RTSSI_CTRL_OFS: begin
        readMux = {31'h00000000, ctrlTimer};
      end
      `RTSSI_STATE_OFS: begin
        readMux = stateWord;
      end
      `RTSSI_IRQST_OFS: begin
        readMux = {28'h0000000, irqStatus};
      end
      `RTSSI_IRQMSK_OFS: begin
        readMux = {28'h0000000, irqMask};
      end
      default: begin
        readMux = 32'h00000000;
      end
    endcase
  end

  // Read data is loaded in the setup cycle so that it already stands
  // when the master samples it at the access edge; it then holds until
  // the next read, so a late sampler still sees the same word
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      prdata <= 32'h00000000;
    end else if (rdSetup) begin
      prdata <= readMux;
    end
  end

  // Control and mask registers take write data at the access edge
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ctrlTimer <= 1'b1;
      irqMask <= {`RTSSI_EV_W{1'b0}};
    end else begin
      if (wr && hitCtrl) begin
        ctrlTimer <= pwdata[`RTSSI_CTRL_TIMER];
      end
      if (wr && hitMsk) begin
        irqMask <= pwdata[`RTSSI_EV_W-1:0];
      end
    end
  end

  // Read clears only the bits that the read returned; an event arriving
  // between setup and access, or in the clearing cycle, still sets its bit
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      irqStatus <= {`RTSSI_EV_W{1'b0}};
    end else if (rd && hitIrq) begin
      irqStatus <= (irqStatus & ~prdata[`RTSSI_EV_W-1:0]) | events;
    end else begin
      irqStatus <= irqStatus | events;
    end
  end

  // Level interrupt, high while any unmasked status bit is set
  assign irq = |(irqStatus & irqMask);

endmodule // rtssi_remote_interlock

// [bench/rtssi_remote_ctrl_model.sv]
// Behavioural model of the external start/stop controller
`timescale 1ns/1ns
module rtssi_remote_ctrl_model #(
  parameter WAIT = 20,
  parameter HOLD = 10
) (
  input  wire  clock,
  input  wire  wantEn,
  input  wire  wantStart,
  input  wire  wantStop,
  input  wire  failSeen,
  output logic remoteEnable_b,
  output logic remoteStart_b,
  output logic remoteStop_b
);
  integer failAge = 0;
  // Age of the fail indication, cleared once fail goes away
  // Keeps counting through the stop pulse so the pulse is never cut short
  always @(posedge clock)
    failAge <= (failSeen || (failAge > WAIT && failAge < WAIT + HOLD)) ? failAge + 1 : 0;
  // Released contacts float high through the pull-ups
  assign remoteEnable_b = !wantEn;
  assign remoteStart_b  = !wantStart;
  // Fail clear waits first, then holds stop longer than qualification
  assign remoteStop_b = !(wantStop || (failAge > WAIT && failAge <= WAIT + HOLD));
endmodule // rtssi_remote_ctrl_model

// [bench/rtssi_remote_interlock_properties.sv]
// Port assertions for the remote start/stop interlock
`timescale 1ns/1ns
`include "rtssi_consts.vh"
module rtssi_remote_interlock_chk #(
  parameter QUAL_CYC = `RTSSI_QUAL_CYC,
  parameter PASS_CYC = `RTSSI_PASS_CYC
) (
  input wire       clock,
  input wire       rst_b,
  input wire       remoteEnable_b,
  input wire       remoteStart_b,
  input wire       remoteStop_b,
  input wire       interlockClosed,
  input wire       outputOn,
  input wire       remoteMode,
  input wire [2:0] testState
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  integer passCnt;
  // Cycles spent in PASS so far
  always @(posedge clock or negedge rst_b)
    if (!rst_b) passCnt <= 0;
    else passCnt <= (testState == `RTSSI_ST_PASS) ? passCnt + 1 : 0;
  integer enHi;
  integer startHi;
  integer stopLo;
  // Consecutive cycles each pin has sat at one level
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enHi <= 0;
      startHi <= 0;
      stopLo <= 0;
    end else begin
      enHi <= remoteEnable_b ? enHi + 1 : 0;
      startHi <= remoteStart_b ? startHi + 1 : 0;
      stopLo <= !remoteStop_b ? stopLo + 1 : 0;
    end
  end
  // Margin covers the synchroniser, the reset release flops and qualification
  sequence enIdle; enHi >= QUAL_CYC + 5; endsequence
  sequence startIdle; startHi >= QUAL_CYC + 5; endsequence
  sequence stopHeld; stopLo >= QUAL_CYC + 5; endsequence
  chk_out_test: assert property (
    outputOn == (testState == `RTSSI_ST_TEST)) else $error("output on outside test");
  chk_panel_mode: assert property (enIdle |=> !remoteMode)
    else $error("remote mode without enable");
  chk_panel_start: assert property (
    startIdle ##0 (remoteMode && testState == `RTSSI_ST_READY) |=> testState != `RTSSI_ST_TEST)
    else $error("test began without remote start");
  chk_remote_stop: assert property (
    stopHeld ##0 remoteMode |=> testState != `RTSSI_ST_TEST) else $error("stop ignored");
  chk_prot_entry: assert property (
    !interlockClosed |=> testState == `RTSSI_ST_PROT) else $error("open loop not protected");
  chk_prot_exit: assert property (testState == `RTSSI_ST_PROT |=>
    testState inside {`RTSSI_ST_PROT, `RTSSI_ST_READY}) else $error("bad protection exit");
  chk_fail_hold: assert property (testState == `RTSSI_ST_FAIL |=>
    testState inside {`RTSSI_ST_FAIL, `RTSSI_ST_READY, `RTSSI_ST_PROT}) else $error("fail lost");
  chk_pass_dwell: assert property (
    $fell(testState == `RTSSI_ST_PASS) && $past(interlockClosed) |-> passCnt == PASS_CYC)
    else $error("pass dwell wrong");
endmodule // rtssi_remote_interlock_chk
bind rtssi_remote_interlock rtssi_remote_interlock_chk #(.QUAL_CYC(QUAL_CYC),
  .PASS_CYC(PASS_CYC)) u_chk (
  .clock, .rst_b, .remoteEnable_b, .remoteStart_b, .remoteStop_b, .interlockClosed,
  .outputOn, .remoteMode, .testState);

// [bench/rtssi_remote_interlock_tb.sv]
// Self-checking bench for the remote start/stop interlock
`timescale 1ns/1ns
`include "rtssi_consts.vh"
module rtssi_remote_interlock_tb;
  logic        clock = 1'h0;
  logic        rst_b = 1'h0;
  logic        wantEn = 1'h0, wantStart = 1'h0, wantStop = 1'h0;
  logic        panelStart = 1'h0, panelStop = 1'h0, interlockClosed = 1'h1;
  logic        timerDone = 1'h0, leakFail = 1'h0, slvErr;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rdVal;
  wire  [31:0] prdata;
  wire  [2:0]  testState;
  wire         pready, pslverr, outputOn, remoteMode, irq;
  wire         remoteEnable_b, remoteStart_b, remoteStop_b;
  integer      err_total = 0, compares = 0, i;
  // Rows: enable, start, stop, panel start, panel stop, loop closed; then mode, state
  logic [9:0]  rows [14] = '{10'h051, 10'h030, 10'h218, 10'h258, 10'h319, 10'h298, 10'h319,
                            10'h238, 10'h20C, 10'h22C, 10'h23C, 10'h21C, 10'h238, 10'h010};
  // Half-period toggle gives 100 ns
  always #50 clock = ~clock;
  rtssi_remote_ctrl_model #(.WAIT(20), .HOLD(10)) partner (.clock, .wantEn, .wantStart,
    .wantStop, .failSeen(testState === `RTSSI_ST_FAIL), .remoteEnable_b, .remoteStart_b,
    .remoteStop_b);
  // Short counts keep the run brief
  rtssi_remote_interlock #(.QUAL_CYC(4), .PASS_CYC(10)) dut (.clock, .rst_b, .remoteEnable_b,
    .remoteStart_b, .remoteStop_b, .panelStart, .panelStop, .interlockClosed, .timerDone,
    .leakFail, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .outputOn, .testState, .remoteMode, .irq);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("Mismatches %0d, compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clock);
  endtask
  // One APB transfer; answer taken at the pready edge, then one idle edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock) penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) @(posedge clock);
    slvErr = pslverr;
    rdVal = prdata;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge clock);
  endtask
  initial begin
    cyc(20); rst_b <= 1'h1; cyc(4);
    for (i = 0; i < 14; i++) begin
      {wantEn, wantStart, wantStop, panelStart, panelStop, interlockClosed} <= rows[i][9:4];
      cyc(14);
      chk({remoteMode, outputOn, testState}, {rows[i][3], rows[i][2:0] == 3'h1, rows[i][2:0]});
    end
    // Fail is held until the controller sends its late stop
    wantEn <= 1'h1; cyc(10); wantStart <= 1'h1; cyc(14);
    chk(testState, `RTSSI_ST_TEST);
    leakFail <= 1'h1; wantStart <= 1'h0; cyc(1); leakFail <= 1'h0; cyc(8);
    chk({outputOn, testState}, {1'h0, `RTSSI_ST_FAIL});
    cyc(30); chk(testState, `RTSSI_ST_READY);
    // Timed pass shows briefly, then returns to ready unaided
    wantStart <= 1'h1; cyc(14); timerDone <= 1'h1; cyc(1); timerDone <= 1'h0; wantStart <= 1'h0;
    cyc(3); chk(testState, `RTSSI_ST_PASS);
    cyc(12); chk(testState, `RTSSI_ST_READY);
    // Pending events stay masked until the mask opens; a read clears them
    apb(1'h0, `RTSSI_IRQMSK_OFS, 32'h0); chk(irq, 1'h0); chk(rdVal, 32'h0);
    apb(1'h1, `RTSSI_IRQMSK_OFS, 32'h0000000F); chk(irq, 1'h1);
    apb(1'h0, `RTSSI_IRQST_OFS, 32'h0); chk(rdVal, 32'h0000000F); chk(irq, 1'h0);
    apb(1'h0, `RTSSI_STATE_OFS, 32'h0); chk(rdVal, 32'h00000030);
    apb(1'h0, 12'h010, 32'h0); chk(slvErr, 1'h1); chk(rdVal, 32'h0);
    // Reset in mid-run drops remote control at once
    rst_b <= 1'h0; cyc(2); chk({remoteMode, testState}, 4'h0);
    // Second release: enable still held, so remote control returns once qualified
    rst_b <= 1'h1; cyc(12);
    chk({remoteMode, outputOn, testState}, {1'h1, 1'h0, `RTSSI_ST_READY});
    apb(1'h0, `RTSSI_IRQMSK_OFS, 32'h0); chk(rdVal, 32'h0); chk(irq, 1'h0);
    conclude;
  end
  // Whole run needs a few hundred cycles
  initial begin
    #300000;
    err_total++;
    conclude;
  end
endmodule // rtssi_remote_interlock_tb
